// File: bench/eepi_master.sv
// two-wire bus master model that drives the eeprom front end from the far side
// assumes a pull-up on sda outside; the bench resolves the wire from both drivers
module eepi_master (
  // timing clock
  input wire logic clk,
  // bus lines
  output logic scl_m,
  output logic sda_m,
  input wire logic sda_i,
  // one pulse per byte: kind 1 is read data, kind 0 is the ack bit
  output logic ev,
  output logic ev_kind,
  output logic [7:0] ev_val
);
  timeunit 1ns;
  timeprecision 1ps;
  // quarter bit; the low phase of 56 cycles leaves room for the target's slow answer
  localparam int Q = 28;

  // bus idle: clock and data released high
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
    ev = 1'b0;
    ev_kind = 1'b0;
    ev_val = 8'h00;
  end

  task automatic wq();
    repeat (Q) @(posedge clk);
  endtask

  // data changes only mid-low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    wq();
    sda_m <= b;
    wq();
    scl_m <= 1'b1;
    wq();
    r = sda_i;
    wq();
    scl_m <= 1'b0;
  endtask

  // start or repeated start: data falls while clock is high
  task automatic start();
    sda_m <= 1'b1;
    wq();
    scl_m <= 1'b1;
    wq();
    sda_m <= 1'b0;
    wq();
    scl_m <= 1'b0;
  endtask

  // stop: data rises while clock is high, leaving the bus idle
  task automatic stop();
    wq();
    sda_m <= 1'b0;
    wq();
    scl_m <= 1'b1;
    wq();
    sda_m <= 1'b1;
    wq();
  endtask

  // one byte msb first plus the ninth clock for the acknowledge
  task automatic xfer(input logic rd, input logic [7:0] d, input logic mack);
    logic [7:0] r;
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(rd ? mack : 1'b1, a);
    ev_kind <= rd;
    ev_val <= rd ? r : {7'h00, a};
    ev <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
  endtask
endmodule

// File: bench/test_eepi_top.sv
// self-checking bench of the eeprom front end: writes, reads, straps, protection
// assumes eepi_top and eepi_master compiled before; pull-up on sda modelled here
`include "eepi_regs.svh"
module test_eepi_top;
  timeunit 1ns;
  timeprecision 1ps;
  // short write cycle keeps the run brief; still long enough to poll during it
  localparam int WRC = 2000;
  logic clk, link_clk, rst_b, scl_m, sda_m, sda_i, sda_o, sda_oe, wp, prog_busy;
  logic ev, ev_kind;
  logic [7:0] ev_val;
  logic [2:0] strap, s;
  logic [11:0] pg;
  logic [7:0] mem [0:4095];
  logic q_ack [$];
  logic [7:0] q_dat [$];
  logic [31:0] bcnt = 32'h0;
  logic [7:0] hi_cnt = 8'h00;
  logic oe_q = 1'b0;
  logic busy_q = 1'b0;
  int error_cnt = 0;
  int checks = 0;

  // wired-and data line: high only while the master and the target both release it
  assign sda_i = sda_m & ~sda_oe;

  eepi_master m (.clk(clk), .scl_m(scl_m), .sda_m(sda_m), .sda_i(sda_i),
    .ev(ev), .ev_kind(ev_kind), .ev_val(ev_val));

  eepi_top #(.WR_CYC(WRC), .FIFO_DEPTH(16)) dut (.clk(clk), .rst_b(rst_b),
    .link_clk(link_clk), .scl_i(scl_m), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .hw_addr_strap_bit0(strap[0]), .hw_addr_strap_bit1(strap[1]),
    .hw_addr_strap_bit2(strap[2]), .write_protect(wp), .prog_busy(prog_busy));

  // two unrelated clocks
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #13;
    forever #40 link_clk = ~link_clk;
  end

  task automatic cmpb(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic cmpv(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic summarize();
    if (error_cnt == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // result watcher: oldest note against what the master saw
  always @(posedge clk) begin
    if (ev === 1'b1 && ev_kind === 1'b1) cmpv("rd_data", q_dat.pop_front(), ev_val);
    if (ev === 1'b1 && ev_kind === 1'b0) cmpb("ack", q_ack.pop_front(), ev_val[0]);
  end
  // target must not move its data drive during a settled clock-high phase
  always @(posedge clk) begin
    hi_cnt <= scl_m ? hi_cnt + 8'h01 : 8'h00;
    oe_q <= sda_oe;
    if (hi_cnt > 8'h14 && hi_cnt < 8'h30) cmpb("sda_oe_stable", oe_q, sda_oe);
    // restart the span on the first busy cycle and hold it after the fall
    if (prog_busy === 1'b1) bcnt <= (busy_q === 1'b1) ? bcnt + 32'h1 : 32'h1;
    busy_q <= prog_busy;
  end
  // open drain: the pin value is low whenever it is enabled; looked at mid-period
  always @(negedge link_clk) if (sda_oe === 1'b1) cmpb("sda_o", 1'b0, sda_o);

  task automatic dev(input logic [2:0] sv, input logic r, input logic ea);
    q_ack.push_back(ea);
    m.xfer(1'b0, {`EEPI_DEV_TYPE, sv, r}, 1'b1);
  endtask
  task automatic wbyte(input logic [7:0] b, input logic ea);
    q_ack.push_back(ea);
    m.xfer(1'b0, b, 1'b1);
  endtask
  task automatic seta(input logic [11:0] a);
    m.start();
    dev(s, 1'b0, 1'b0);
    wbyte({4'h0, a[11:8]}, 1'b0);
    wbyte(a[7:0], 1'b0);
  endtask
  // page write; offsets wrap inside the 32-byte page, protected bytes still acked
  task automatic wpage(input logic [11:0] a, input int n);
    logic [7:0] b;
    logic [4:0] o;
    seta(a);
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom);
      o = a[4:0] + 5'(i);
      if (wp === 1'b0) mem[{a[11:5], o}] = b;
      wbyte(b, 1'b0);
    end
    m.stop();
  endtask
  // random read then sequential bytes, last one not acknowledged
  task automatic rd(input logic [11:0] a, input int n);
    seta(a);
    m.start();
    dev(s, 1'b1, 1'b0);
    for (int i = 0; i < n; i++) begin
      q_dat.push_back(mem[12'(a + 12'(i))]);
      m.xfer(1'b1, 8'hff, i == n - 1);
    end
    m.stop();
  endtask
  task automatic wait_lvl(input logic lvl, input int lim);
    for (int i = 0; i < lim && prog_busy !== lvl; i++) @(negedge clk);
    cmpb("prog_busy", lvl, prog_busy);
  endtask
  // self-timed cycle: address refused while busy, then an exact busy span
  task automatic wcommit();
    wait_lvl(1'b1, 400);
    m.start();
    dev(s, 1'b0, 1'b1);
    m.stop();
    wait_lvl(1'b0, WRC + 400);
    cmpv("busy_len", WRC, bcnt);
  endtask

  // watchdog above the expected run of about 80k cycles, inside the 100k budget
  initial begin
    repeat (95000) @(posedge clk);
    error_cnt++;
    summarize();
  end

  initial begin
    rst_b = 1'b0;
    strap = 3'h0;
    s = 3'h0;
    wp = 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (60) @(posedge clk);
    void'($urandom(32'h6346caeb));
    // straps left at zero as open pins, then a random strapping; all eight addresses
    for (int p = 0; p < 2; p++) begin
      s = p ? 3'($urandom) : 3'h0;
      strap <= s;
      repeat (40) @(posedge clk);
      for (int k = 0; k < 8; k++) begin
        m.start();
        dev(3'(k), 1'b0, 3'(k) != s);
        m.stop();
      end
    end
    pg = 12'($urandom);
    wpage({pg[11:5], 5'h14}, 16);
    wcommit();
    rd({pg[11:5], 5'h14}, 12);
    rd({pg[11:5], 5'h00}, 4);
    // protected write: acked, yet no cycle and no change
    wp <= 1'b1;
    wpage({pg[11:5], 5'h14}, 2);
    repeat (300) @(negedge clk);
    cmpb("prog_busy", 1'b0, prog_busy);
    rd({pg[11:5], 5'h14}, 2);
    wp <= 1'b0;
    cmpv("notes_left", 32'h0, 32'(q_ack.size() + q_dat.size()));
    summarize();
  end
endmodule

// File: rtl/eepi_fifo.sv
// single-clock fifo with valid/ready on both sides, flop storage
// assumes DEPTH is a power of two so pointers wrap by overflow
module eepi_fifo import eepi_pkg::*; #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
    $error("eepi_fifo: DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } eepi_fifo_st_t;

  eepi_fifo_st_t s;
  eepi_fifo_st_t nxt_s;
  logic push;
  logic pop;

  assign in_ready = (s.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s.cnt != '0);
  assign out_data = s.mem[s.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // count moves only when exactly one side transfers
  always_comb begin
    nxt_s = s;
    if (push) begin
      nxt_s.mem[s.wp] = in_data;
      nxt_s.wp = s.wp + 1'b1;
    end
    if (pop) begin
      nxt_s.rp = s.rp + 1'b1;
    end
    if (push && !pop) begin
      nxt_s.cnt = s.cnt + 1'b1;
    end else if (pop && !push) begin
      nxt_s.cnt = s.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= nxt_s;
    end
  end
endmodule

// File: rtl/eepi_pkg.sv
// types of the serial eeprom target front end: link states, crossing word, module states
// assumes eepi_regs.svh on the include path
package eepi_pkg;
  `include "eepi_regs.svh"

  // link protocol states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV = 3'b001,
    ST_AHI = 3'b010,
    ST_ALO = 3'b011,
    ST_WR = 3'b100,
    ST_RD = 3'b101
  } eepi_lst_t;

  // word handed from the link to the array side; commit closes a page
  typedef struct packed {
    logic commit;
    logic [`EEPI_ADDR_W-1:0] addr;
    logic [7:0] data;
  } eepi_wword_t;

  typedef struct packed {
    eepi_lst_t st;
    logic [3:0] bit_cnt;
    logic ack_ph;
    logic m_nack;
    logic [7:0] shreg;
    logic [7:0] rd_sh;
    logic [7:0] rd_data;
    logic [`EEPI_ADDR_W-1:0] ptr;
    logic [`EEPI_ADDR_W-1:0] r_addr;
    logic r_tog;
    logic r_ack_seen;
    eepi_wword_t w_word;
    logic w_tog;
    logic commit_pend;
    logic wr_any;
    logic [2:0] strap;
    logic scl_p;
    logic sda_p;
    logic sda_oe;
    logic sda_o;
  } eepi_link_t;

  typedef struct packed {
    logic w_seen;
    logic r_seen;
    logic [7:0] rd_data;
    logic busy;
    logic [5:0] prog_idx;
    logic [`EEPI_TMR_W-1:0] timer;
    logic [`EEPI_ADDR_W-`EEPI_PAGE_W-1:0] page_base;
    logic [`EEPI_PAGE_BYTES-1:0][7:0] pbuf;
    logic [`EEPI_PAGE_BYTES-1:0] pmask;
  } eepi_core_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } eepi_sync_t;
endpackage

// File: rtl/eepi_regs.svh
// constants of the serial eeprom target front end: address layout, page size, timing
// assumes inclusion by eepi_pkg and by the top module, by bare name
`ifndef EEPI_REGS_SVH
`define EEPI_REGS_SVH
`define EEPI_DEV_TYPE 4'ha
`define EEPI_ADDR_W 12
`define EEPI_PAGE_W 5
`define EEPI_PAGE_BYTES 32
`define EEPI_T_WR_NS 5000000
`define EEPI_CLK_NS 20
`define EEPI_WR_CYC (`EEPI_T_WR_NS / `EEPI_CLK_NS)
`define EEPI_TMR_W 20
`define EEPI_FIFO_DEPTH 16
`endif

// File: rtl/eepi_sync.sv
// three-flop synchroniser for one bit, with optional agreement filter
// assumes d comes from another domain or a pin; q is registered
module eepi_sync import eepi_pkg::*; #(
  parameter bit FILTER = 1'b0,
  parameter bit RST_VAL = 1'b0
) (
  // clock and reset of the receiving domain
  input wire logic clk,
  input wire logic rst_b,
  // asynchronous input and its synchronised image
  input wire logic d,
  output logic q
);
  eepi_sync_t s;
  eepi_sync_t nxt_s;

  // s1 feeds only s2; the filter takes a change once s2 and s3 agree
  always_comb begin
    nxt_s = s;
    nxt_s.s1 = d;
    nxt_s.s2 = s.s1;
    nxt_s.s3 = s.s2;
    if (FILTER) begin
      nxt_s.q = (s.s2 == s.s3) ? s.s3 : s.q;
    end else begin
      nxt_s.q = s.s2;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= {4{RST_VAL}};
    end else begin
      s <= nxt_s;
    end
  end

  assign q = s.q;
endmodule

// File: rtl/eepi_top.sv
// serial eeprom two-wire target: pin protocol on link_clk, array and write cycle on clk
// assumes scl_i/sda_i are the resolved bus levels and the pad pulls straps and wp low
`include "eepi_regs.svh"
module eepi_top import eepi_pkg::*; #(
  parameter int WR_CYC = `EEPI_WR_CYC,
  parameter int FIFO_DEPTH = `EEPI_FIFO_DEPTH
) (
  // system clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // link oversampling clock
  input wire logic link_clk,
  // two-wire bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // straps and protection
  input wire logic hw_addr_strap_bit0,
  input wire logic hw_addr_strap_bit1,
  input wire logic hw_addr_strap_bit2,
  input wire logic write_protect,
  // status
  output logic prog_busy
);
  if (WR_CYC <= `EEPI_PAGE_BYTES || WR_CYC >= (1 << `EEPI_TMR_W)) begin : g_chk
    $error("eepi_top: WR_CYC out of range");
  end

  // next address inside the same page
  function automatic logic [`EEPI_ADDR_W-1:0] page_next(input logic [`EEPI_ADDR_W-1:0] a);
    page_next = {a[`EEPI_ADDR_W-1:`EEPI_PAGE_W], a[`EEPI_PAGE_W-1:0] + 1'b1};
  endfunction

  eepi_link_t l;
  eepi_link_t nxt_l;
  eepi_core_t c;
  eepi_core_t nxt_c;
  logic scl_s, sda_s, busy_s, w_ack_s, r_ack_s, wp_s, w_tog_s, r_tog_s;
  logic [2:0] strap_s;
  logic scl_rise, scl_fall, start_c, stop_c, any_edge, chan_free, byte_done, dev_match;
  logic f_in_valid, f_in_ready, f_out_valid, pop;
  eepi_wword_t f_out;
  logic mem_we;
  logic [`EEPI_ADDR_W-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic [7:0] mem [0:(1 << `EEPI_ADDR_W)-1];

  // pins pass three flops and the agreement filter before any edge logic
  eepi_sync #(.FILTER(1'b1), .RST_VAL(1'b1)) u_scl (
    .clk(link_clk), .rst_b(rst_b), .d(scl_i), .q(scl_s));
  eepi_sync #(.FILTER(1'b1), .RST_VAL(1'b1)) u_sda (
    .clk(link_clk), .rst_b(rst_b), .d(sda_i), .q(sda_s));
  // straps and wp reset to low, the level an open pin settles to
  eepi_sync #(.FILTER(1'b1), .RST_VAL(1'b0)) u_st0 (
    .clk(link_clk), .rst_b(rst_b), .d(hw_addr_strap_bit0), .q(strap_s[0]));
  eepi_sync #(.FILTER(1'b1), .RST_VAL(1'b0)) u_st1 (
    .clk(link_clk), .rst_b(rst_b), .d(hw_addr_strap_bit1), .q(strap_s[1]));
  eepi_sync #(.FILTER(1'b1), .RST_VAL(1'b0)) u_st2 (
    .clk(link_clk), .rst_b(rst_b), .d(hw_addr_strap_bit2), .q(strap_s[2]));
  eepi_sync #(.FILTER(1'b1), .RST_VAL(1'b0)) u_wp (
    .clk(clk), .rst_b(rst_b), .d(write_protect), .q(wp_s));
  // handshake toggles and the busy level between the two domains
  eepi_sync u_busy (.clk(link_clk), .rst_b(rst_b), .d(c.busy), .q(busy_s));
  eepi_sync u_wack (.clk(link_clk), .rst_b(rst_b), .d(c.w_seen), .q(w_ack_s));
  eepi_sync u_rack (.clk(link_clk), .rst_b(rst_b), .d(c.r_seen), .q(r_ack_s));
  eepi_sync u_wtog (.clk(clk), .rst_b(rst_b), .d(l.w_tog), .q(w_tog_s));
  eepi_sync u_rtog (.clk(clk), .rst_b(rst_b), .d(l.r_tog), .q(r_tog_s));

  // bus events from the filtered samples
  assign scl_rise = scl_s && !l.scl_p;
  assign scl_fall = !scl_s && l.scl_p;
  assign start_c = l.scl_p && scl_s && l.sda_p && !sda_s;
  assign stop_c = l.scl_p && scl_s && !l.sda_p && sda_s;
  assign any_edge = scl_fall || start_c || stop_c;
  assign chan_free = (w_ack_s == l.w_tog) && !l.commit_pend;
  assign byte_done = scl_fall && !l.ack_ph && (l.bit_cnt == 4'h8) && (l.st != ST_IDLE)
                     && !start_c && !stop_c;
  // device type plus strapped bits; eight strap codes give eight targets
  assign dev_match = (l.shreg[7:4] == `EEPI_DEV_TYPE) && (l.shreg[3:1] == l.strap);

  // link protocol engine; idle waits on a high clock held by the master
  always_comb begin
    nxt_l = l;
    nxt_l.scl_p = scl_s;
    nxt_l.sda_p = sda_s;
    nxt_l.strap = strap_s;
    nxt_l.sda_o = 1'b0; // only ever pull low
    // read answer arrives by handshake, data is stable once the toggle is seen
    if (r_ack_s != l.r_ack_seen) begin
      nxt_l.r_ack_seen = r_ack_s;
      nxt_l.rd_data = c.rd_data;
    end
    if (l.commit_pend && (w_ack_s == l.w_tog)) begin
      nxt_l.w_word = '{commit: 1'b1, addr: l.ptr, data: 8'h00};
      nxt_l.w_tog = !l.w_tog;
      nxt_l.commit_pend = 1'b0;
    end
    if (start_c || stop_c) begin
      // a stop or repeated start after write bytes closes the page
      if (l.st == ST_WR && l.wr_any) begin
        nxt_l.commit_pend = 1'b1;
      end
      nxt_l.wr_any = 1'b0;
      nxt_l.sda_oe = 1'b0;
      nxt_l.ack_ph = 1'b0;
      nxt_l.bit_cnt = 4'h0;
      nxt_l.st = start_c ? ST_DEV : ST_IDLE;
    end else if (l.st != ST_IDLE) begin
      if (scl_rise) begin
        if (l.ack_ph) begin
          nxt_l.m_nack = sda_s;
        end else if (l.bit_cnt < 4'h8) begin
          nxt_l.shreg = {l.shreg[6:0], sda_s}; // msb first, taken on rise
          nxt_l.bit_cnt = l.bit_cnt + 4'h1;
        end
      end
      if (scl_fall) begin
        if (l.ack_ph) begin
          // end of the ninth clock: release, or start the next read byte
          nxt_l.ack_ph = 1'b0;
          nxt_l.bit_cnt = 4'h0;
          nxt_l.sda_oe = 1'b0;
          if (l.st == ST_RD) begin
            if (l.m_nack) begin
              nxt_l.st = ST_IDLE;
            end else begin
              nxt_l.sda_oe = !l.rd_data[7];
              nxt_l.rd_sh = {l.rd_data[6:0], 1'b0};
            end
          end
        end else if (l.bit_cnt == 4'h8) begin
          nxt_l.ack_ph = 1'b1;
          nxt_l.sda_oe = 1'b0;
          case (l.st)
            ST_DEV: begin
              // busy programming answers no acknowledge
              if (dev_match && !busy_s) begin
                nxt_l.sda_oe = 1'b1;
                nxt_l.m_nack = 1'b0;
                if (l.shreg[0]) begin
                  nxt_l.st = ST_RD; // read at the current address
                  nxt_l.r_addr = l.ptr;
                  nxt_l.r_tog = !l.r_tog;
                  nxt_l.ptr = l.ptr + 12'h001;
                end else begin
                  nxt_l.st = ST_AHI;
                end
              end else begin
                nxt_l.st = ST_IDLE;
              end
            end
            ST_AHI: begin
              nxt_l.sda_oe = 1'b1;
              nxt_l.ptr[11:8] = l.shreg[3:0];
              nxt_l.st = ST_ALO;
            end
            ST_ALO: begin
              nxt_l.sda_oe = 1'b1;
              nxt_l.ptr[7:0] = l.shreg;
              nxt_l.st = ST_WR;
            end
            ST_WR: begin
              // a byte is acknowledged only if the crossing can take it
              if (chan_free) begin
                nxt_l.sda_oe = 1'b1;
                nxt_l.w_word = '{commit: 1'b0, addr: l.ptr, data: l.shreg};
                nxt_l.w_tog = !l.w_tog;
                nxt_l.ptr = page_next(l.ptr);
                nxt_l.wr_any = 1'b1;
              end
            end
            ST_RD: begin
              // prefetch the next byte while the master answers
              nxt_l.r_addr = l.ptr;
              nxt_l.r_tog = !l.r_tog;
              nxt_l.ptr = l.ptr + 12'h001;
            end
            default: begin
              nxt_l.st = ST_IDLE;
            end
          endcase
        end else if (l.st == ST_RD) begin
          nxt_l.sda_oe = !l.rd_sh[7];
          nxt_l.rd_sh = {l.rd_sh[6:0], 1'b0};
        end
      end
    end
  end
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      l <= '0;
      l.scl_p <= 1'b1;
      l.sda_p <= 1'b1;
    end else begin
      l <= nxt_l;
    end
  end
  assign sda_o = l.sda_o;
  assign sda_oe = l.sda_oe;
  // page words wait here; the drain stalls during programming, while the device address is nacked
  eepi_fifo #(.WIDTH($bits(eepi_wword_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk), .rst_b(rst_b),
    .in_valid(f_in_valid), .in_ready(f_in_ready), .in_data(l.w_word),
    .out_valid(f_out_valid), .out_ready(!c.busy), .out_data(f_out));
  assign f_in_valid = (w_tog_s != c.w_seen);
  assign pop = f_out_valid && !c.busy;

  // array side: read service, page buffer, self-timed programming
  always_comb begin
    nxt_c = c;
    mem_we = 1'b0;
    mem_wa = {c.page_base, c.prog_idx[`EEPI_PAGE_W-1:0]};
    mem_wd = c.pbuf[c.prog_idx[`EEPI_PAGE_W-1:0]];
    if (r_tog_s != c.r_seen) begin
      nxt_c.r_seen = r_tog_s;
      nxt_c.rd_data = mem[l.r_addr];
    end
    if (f_in_valid && f_in_ready) begin
      nxt_c.w_seen = w_tog_s;
    end
    if (pop) begin
      if (f_out.commit) begin
        // protection drops the page instead of programming it
        if ((c.pmask != '0) && !wp_s) begin
          nxt_c.busy = 1'b1;
          nxt_c.timer = '0;
          nxt_c.prog_idx = 6'h00;
        end else begin
          nxt_c.pmask = '0;
        end
      end else begin
        nxt_c.page_base = f_out.addr[`EEPI_ADDR_W-1:`EEPI_PAGE_W];
        nxt_c.pbuf[f_out.addr[`EEPI_PAGE_W-1:0]] = f_out.data;
        nxt_c.pmask[f_out.addr[`EEPI_PAGE_W-1:0]] = 1'b1;
      end
    end
    if (c.busy) begin
      // one byte a cycle, then wait out the fixed write time
      nxt_c.timer = c.timer + 1'b1;
      if (c.prog_idx < 6'h20) begin
        mem_we = c.pmask[c.prog_idx[`EEPI_PAGE_W-1:0]] && !wp_s;
        nxt_c.prog_idx = c.prog_idx + 6'h01;
      end
      if (c.timer == `EEPI_TMR_W'(WR_CYC - 1)) begin
        nxt_c.busy = 1'b0;
        nxt_c.pmask = '0;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      c <= '0;
    end else begin
      c <= nxt_c;
    end
  end
  // array contents are not reset, as in a nonvolatile part
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end
  assign prog_busy = c.busy;
  // helper: length of the current write cycle
  logic [`EEPI_TMR_W-1:0] bcnt_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bcnt_ff <= '0;
    end else begin
      bcnt_ff <= c.busy ? bcnt_ff + 1'b1 : '0;
    end
  end

  a_strap_mismatch: assert property (@(posedge link_clk) disable iff (!rst_b)
    (byte_done && l.st == ST_DEV && l.shreg[3:1] != l.strap) |=> (!l.sda_oe && l.st == ST_IDLE))
    else $error("strap mismatch was acknowledged");
  a_strap_match: assert property (@(posedge link_clk) disable iff (!rst_b)
    (byte_done && l.st == ST_DEV && dev_match && !busy_s) |=> l.sda_oe)
    else $error("matching address not acknowledged");
  a_capture_rise: assert property (@(posedge link_clk) disable iff (!rst_b)
    (l.st != ST_IDLE && !start_c && !stop_c && scl_rise && !l.ack_ph && l.bit_cnt < 4'h8)
    |=> (l.shreg[0] == $past(sda_s)))
    else $error("data bit not taken on clock rise");
  a_drive_on_fall: assert property (@(posedge link_clk) disable iff (!rst_b)
    $changed(l.sda_oe) |-> $past(any_edge))
    else $error("data drive changed outside a falling clock");
  a_never_high: assert property (@(posedge link_clk) disable iff (!rst_b)
    !l.sda_o)
    else $error("data pin driven high");
  a_start_detect: assert property (@(posedge link_clk) disable iff (!rst_b)
    start_c |=> (l.st == ST_DEV && l.bit_cnt == 4'h0 && !l.sda_oe))
    else $error("start not taken");
  a_stop_detect: assert property (@(posedge link_clk) disable iff (!rst_b)
    stop_c |=> (l.st == ST_IDLE && !l.sda_oe))
    else $error("stop not taken");
  a_msb_first: assert property (@(posedge link_clk) disable iff (!rst_b)
    (scl_fall && l.ack_ph && l.st == ST_RD && !l.m_nack && !start_c && !stop_c)
    |=> (l.sda_oe == !$past(l.rd_data[7])))
    else $error("read byte not started with its msb");
  a_page_wrap: assert property (@(posedge link_clk) disable iff (!rst_b)
    (byte_done && l.st == ST_WR && chan_free) |=> (l.ptr == page_next($past(l.ptr))))
    else $error("write address left its page");
  a_seq_read: assert property (@(posedge link_clk) disable iff (!rst_b)
    (byte_done && l.st == ST_RD) |=> (l.ptr == $past(l.ptr) + 12'h001 && $changed(l.r_tog)))
    else $error("sequential read did not advance");
  a_wp_blocks: assert property (@(posedge clk) disable iff (!rst_b)
    (pop && f_out.commit && wp_s) |=> (!c.busy && c.pmask == '0))
    else $error("protected page was programmed");
  a_prog_bound: assert property (@(posedge clk) disable iff (!rst_b)
    !(c.busy && bcnt_ff >= `EEPI_TMR_W'(WR_CYC)))
    else $error("write cycle overran its time");
  a_array_write: assert property (@(posedge clk) disable iff (!rst_b)
    mem_we |-> (c.busy && c.pmask[c.prog_idx[`EEPI_PAGE_W-1:0]] && !wp_s))
    else $error("array written outside a write cycle");

  c_write_done: cover property (@(posedge clk) disable iff (!rst_b) $fell(c.busy));
  c_wp_drop: cover property (@(posedge clk) disable iff (!rst_b) pop && f_out.commit && wp_s);
  c_seq_read: cover property (@(posedge link_clk) disable iff (!rst_b)
    byte_done && l.st == ST_RD && !l.m_nack);
  c_addr_nack: cover property (@(posedge link_clk) disable iff (!rst_b)
    byte_done && l.st == ST_DEV && !dev_match);
endmodule
